// ==== include/freq_ref_pkg.sv ====
// Constants for the frequency reference and pulse counter block
package freq_ref_pkg;

  // Widths
  localparam int FW  = 16;  // Frequency word, signed, units of 0.01 Hz
  localparam int PW  = 16;  // Percent word, 0..10000 = 0..100.00 %
  localparam int CW  = 32;  // Counter width

  // Percent full scale (100.00 %)
  localparam logic [PW-1:0] PCT_FULL = 16'h2710;

  // Main and auxiliary source codes
  localparam logic [3:0] SRC_DIG_VOL  = 4'h0;
  localparam logic [3:0] SRC_DIG_RET  = 4'h1;
  localparam logic [3:0] SRC_AIN1     = 4'h2;
  localparam logic [3:0] SRC_AIN2     = 4'h3;
  localparam logic [3:0] SRC_AIN3     = 4'h4;
  localparam logic [3:0] SRC_PULSE    = 4'h5;
  localparam logic [3:0] SRC_MULTI    = 4'h6;
  localparam logic [3:0] SRC_PLC      = 4'h7;
  localparam logic [3:0] SRC_PID      = 4'h8;
  localparam logic [3:0] SRC_COMM     = 4'h9;

  // Source relation codes
  localparam logic [2:0] REL_A        = 3'h0;
  localparam logic [2:0] REL_B        = 3'h1;
  localparam logic [2:0] REL_OP       = 3'h2;
  localparam logic [2:0] REL_SW_AB    = 3'h3;
  localparam logic [2:0] REL_SW_AOP   = 3'h4;
  localparam logic [2:0] REL_SW_BOP   = 3'h5;

  // Combination operations
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_SUB = 2'h1;
  localparam logic [1:0] OP_MAX = 2'h2;
  localparam logic [1:0] OP_MIN = 2'h3;

  // Digital input function codes
  localparam logic [5:0] FN_MS_BIT0   = 6'h0C;
  localparam logic [5:0] FN_COUNT_IN  = 6'h19;
  localparam logic [5:0] FN_LEN_IN    = 6'h1B;
  localparam logic [5:0] FN_LEN_RST   = 6'h1C;
  localparam logic [5:0] FN_CNT_RST   = 6'h1A;

  // Digital output function codes
  localparam logic [5:0] DO_SET_CNT   = 6'h08;
  localparam logic [5:0] DO_DES_CNT   = 6'h09;
  localparam logic [5:0] DO_LEN_REACH = 6'h0A;

  // Terminal counts
  localparam int NUM_DI   = 10;
  localparam int NUM_DO   = 4;
  localparam int PULSE_DI = 4;  // Index of the fifth digital input

  // Reset values
  localparam logic [CW-1:0] CNT_RST = 32'h0000_0000;

endpackage

// ==== rtl/edge_pulse.sv ====
// Two-stage synchroniser with rising edge detector
`timescale 1ns/1ps
module edge_pulse
  import freq_ref_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // Raw level in, one-cycle pulse out
  input  wire logic din,
  output logic      rise
);

  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;

  // Next state of the sync chain
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Sync chain registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // One pulse per rising edge
  assign rise = s2_q & ~s3_q;

  a_single_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    rise |=> !rise) else $error("edge pulse lasted two cycles");

endmodule // edge_pulse

// ==== rtl/freq_ref_core.sv ====
// Frequency reference selection, direction and pulse counters
`timescale 1ns/1ps
// Overview of operation
// - Main reference from one of ten sources
// - A or B alone passes unmodified
// - Combine as sum, difference, max, min
// - Terminal switches between A, B, combined
// - Nonzero binding digit overrides both references
// - Analog 100 percent maps to max frequency
// - Five selectable analog mapping curves
// - Pulse reference only on fifth input
// - Two PID units, auto or terminal switch
// - Sixteen speeds via input functions twelve-fifteen
// - Indexed table percent times max frequency gives target
// - Unassigned speed bits read as zero
// - Direction invert reverses all run commands
// - Negative communication frequency commands reverse
// - Reverse inhibited gives zero frequency output
// - Length from pulses over pulses per meter
// - Length reset input clears length count
// - Length input only on fifth input
// - Count reaches set value, output on, stop
// - Designated value turns output on, continues
// - Counter retained, counts in run and stop
module freq_ref_core
  import freq_ref_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Source configuration
  input  wire logic [3:0]           main_source_select,
  input  wire logic [3:0]           aux_source_select,
  input  wire logic [2:0]           source_relation_select,
  input  wire logic [1:0]           combine_op,
  input  wire logic [1:0]           command_source_select,
  input  wire logic [11:0]          binding_select,
  input  wire logic [FW-1:0]        max_frequency,
  input  wire logic                 direction_invert,
  input  wire logic                 reverse_inhibit,
  // Analog curves: per input curve choice, five curves of two points
  input  wire logic [8:0]           curve_select,
  input  wire logic [5*4*PW-1:0]    curve_points,
  input  wire logic [3*PW-1:0]      ain_pct,
  // Pulse line points: in min, pct min, in max, pct max
  input  wire logic [4*PW-1:0]      pulse_points,
  input  wire logic [PW-1:0]        pulse_rate_khz10,
  // Other frequency and percent references
  input  wire logic [FW-1:0]        dig_vol_freq,
  input  wire logic [FW-1:0]        dig_ret_freq,
  input  wire logic [PW-1:0]        plc_pct,
  input  wire logic signed [FW-1:0] comm_freq,
  // PID units and multi-speed table
  input  wire logic [PW-1:0]        pid1_pct,
  input  wire logic [PW-1:0]        pid2_pct,
  input  wire logic                 pid_auto_sel,
  input  wire logic [15:0]          ms_table [16],
  // Terminals
  input  wire logic [NUM_DI-1:0]    di,
  input  wire logic [6*NUM_DI-1:0]  di_func,
  input  wire logic [6*NUM_DO-1:0]  do_func,
  input  wire logic                 fwd_run,
  input  wire logic                 rev_run,
  input  wire logic                 switch_pin,
  input  wire logic                 pid_switch_pin,
  // Counter configuration
  input  wire logic [CW-1:0]        pulses_per_meter,
  input  wire logic [CW-1:0]        set_length,
  input  wire logic [CW-1:0]        set_count,
  input  wire logic [CW-1:0]        designated_count,
  // Results
  output logic [FW-1:0]             target_freq,
  output logic                      run_reverse,
  output logic                      output_enable,
  output logic [CW-1:0]             actual_length,
  output logic [CW-1:0]             event_count,
  output logic [NUM_DO-1:0]         dout
);

  // Maps a percent to a frequency against max_frequency
  function automatic logic [FW-1:0] pct_to_freq(input logic [PW-1:0] p, input logic [FW-1:0] fmax);
    logic [PW+FW-1:0] prod;
    prod = p * fmax;
    return FW'(prod / PCT_FULL);
  endfunction

  // Two-point line, clamped to the endpoints
  function automatic logic [PW-1:0] line2(input logic [PW-1:0] x, input logic [4*PW-1:0] pts);
    logic [PW-1:0] x0, y0, x1, y1;
    logic [2*PW:0] t;
    x0 = pts[PW-1:0];
    y0 = pts[2*PW-1:PW];
    x1 = pts[3*PW-1:2*PW];
    y1 = pts[4*PW-1:3*PW];
    t = '0;
    if (x <= x0 || x1 <= x0) begin
      line2 = y0;
    end else if (x >= x1) begin
      line2 = y1;
    end else begin
      t = (2*PW+1)'(x - x0) * (2*PW+1)'(y1 - y0);
      line2 = PW'(y0 + PW'(t / (2*PW+1)'(x1 - x0)));
    end
  endfunction

  // Edge pulses on counting inputs
  logic len_pulse, cnt_pulse;
  logic len_assigned, cnt_in, len_rst, cnt_rst, pid_sel;
  logic [3:0] ms_idx;

  // Function decode of digital inputs
  always_comb begin
    len_assigned = (di_func[6*PULSE_DI +: 6] == FN_LEN_IN);
    cnt_in  = 1'b0;
    len_rst = 1'b0;
    cnt_rst = 1'b0;
    ms_idx  = 4'h0;
    pid_sel = pid_auto_sel;
    for (int i = 0; i < NUM_DI; i++) begin
      if (di_func[6*i +: 6] == FN_COUNT_IN) cnt_in = cnt_in | di[i];
      if (di_func[6*i +: 6] == FN_LEN_RST) len_rst = len_rst | di[i];
      if (di_func[6*i +: 6] == FN_CNT_RST) cnt_rst = cnt_rst | di[i];
      for (int b = 0; b < 4; b++) begin
        if (di_func[6*i +: 6] == FN_MS_BIT0 + 6'(b)) ms_idx[b] = ms_idx[b] | di[i];
      end
    end
    if (pid_switch_pin) pid_sel = 1'b1;
  end

  // Pulse synchronisers
  edge_pulse u_len (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (di[PULSE_DI] & len_assigned),
    .rise    (len_pulse)
  );
  edge_pulse u_cnt (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (cnt_in),
    .rise    (cnt_pulse)
  );

  // Reference per source code
  function automatic logic signed [FW:0] src_freq(input logic [3:0] s, input logic [FW-1:0] fmax,
      input logic [3*PW-1:0] ain_map, input logic [PW-1:0] pls, input logic [PW-1:0] ms,
      input logic [PW-1:0] pid, input logic [FW-1:0] dv, input logic [FW-1:0] dr,
      input logic [PW-1:0] plc, input logic signed [FW-1:0] cf);
    case (s)
      SRC_DIG_VOL: src_freq = {1'b0, dv};
      SRC_DIG_RET: src_freq = {1'b0, dr};
      SRC_AIN1:    src_freq = {1'b0, pct_to_freq(ain_map[PW-1:0], fmax)};
      SRC_AIN2:    src_freq = {1'b0, pct_to_freq(ain_map[2*PW-1:PW], fmax)};
      SRC_AIN3:    src_freq = {1'b0, pct_to_freq(ain_map[3*PW-1:2*PW], fmax)};
      SRC_PULSE:   src_freq = {1'b0, pct_to_freq(pls, fmax)};
      SRC_MULTI:   src_freq = {1'b0, pct_to_freq(ms, fmax)};
      SRC_PLC:     src_freq = {1'b0, pct_to_freq(plc, fmax)};
      SRC_PID:     src_freq = {1'b0, pct_to_freq(pid, fmax)};
      SRC_COMM:    src_freq = (FW+1)'(cf);
      default:     src_freq = '0;
    endcase
  endfunction

  logic [3*PW-1:0] ain_map;
  logic [PW-1:0] pls_pct, ms_pct, pid_pct;
  logic signed [FW:0] fa, fb, fop, fsel, fbind, fset;
  logic [3:0] bind_digit;
  logic [2:0] csel;

  // Source mapping and target selection
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      csel = 3'(curve_select[3*k +: 3]);
      if (csel > 3'h4) csel = 3'h0;
      ain_map[PW*k +: PW] = line2(ain_pct[PW*k +: PW], curve_points[4*PW*csel +: 4*PW]);
    end
    pls_pct = line2(pulse_rate_khz10, pulse_points);
    ms_pct  = ms_table[ms_idx];
    pid_pct = pid_sel ? pid2_pct : pid1_pct;
    fa = src_freq(main_source_select, max_frequency, ain_map, pls_pct, ms_pct, pid_pct,
                  dig_vol_freq, dig_ret_freq, plc_pct, comm_freq);
    fb = src_freq(aux_source_select, max_frequency, ain_map, pls_pct, ms_pct, pid_pct,
                  dig_vol_freq, dig_ret_freq, plc_pct, comm_freq);
    case (combine_op)
      OP_ADD:  fop = fa + fb;
      OP_SUB:  fop = fa - fb;
      OP_MAX:  fop = (fa > fb) ? fa : fb;
      default: fop = (fa < fb) ? fa : fb;
    endcase
    case (source_relation_select)
      REL_A:      fsel = fa;
      REL_B:      fsel = fb;
      REL_OP:     fsel = fop;
      REL_SW_AB:  fsel = switch_pin ? fb : fa;
      REL_SW_AOP: fsel = switch_pin ? fop : fa;
      REL_SW_BOP: fsel = switch_pin ? fop : fb;
      default:    fsel = fa;
    endcase
    bind_digit = binding_select[4*command_source_select +: 4];
    fbind = src_freq(bind_digit - 4'h1, max_frequency, ain_map, pls_pct, ms_pct, pid_pct,
                     dig_vol_freq, dig_ret_freq, plc_pct, comm_freq);
    fset = (bind_digit != 4'h0) ? fbind : fsel;
  end

  // Registered frequency and direction state
  logic [FW-1:0] freq_q, freq_d;
  logic rev_q, rev_d, en_q, en_d;
  logic neg;

  // Direction and inhibit
  always_comb begin
    neg    = fset[FW];
    rev_d  = (rev_run & ~fwd_run) ^ neg;
    freq_d = neg ? FW'(-fset) : FW'(fset);
    en_d   = fwd_run | rev_run;
    if (reverse_inhibit && ((rev_run && !fwd_run) || neg)) begin
      freq_d = '0;
      en_d   = 1'b0;
      rev_d  = 1'b0;
    end
    rev_d = rev_d ^ direction_invert;
  end

  // Frequency and direction registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      freq_q <= '0;
      rev_q  <= 1'b0;
      en_q   <= 1'b0;
    end else begin
      freq_q <= freq_d;
      rev_q  <= rev_d;
      en_q   <= en_d;
    end
  end

  // Registered reference results
  assign target_freq   = freq_q;
  assign run_reverse   = rev_q;
  assign output_enable = en_q;

  // Length and event counters; event count is the retained copy
  logic [CW-1:0] len_q, len_d, ev_q, ev_d, alen_q, alen_d;
  logic set_hit_q, set_hit_d, des_hit_q, des_hit_d, len_hit_q, len_hit_d;

  // Counter next values; clear wins over a pulse
  always_comb begin
    len_d = len_q;
    ev_d  = ev_q;
    if (len_rst) begin
      len_d = CNT_RST;
    end else if (len_pulse) begin
      len_d = len_q + 32'h1;
    end
    if (cnt_rst) begin
      ev_d = CNT_RST;
    end else if (cnt_pulse && ev_q < set_count) begin
      ev_d = ev_q + 32'h1;
    end
    alen_d = (pulses_per_meter == '0) ? '0 : len_d / pulses_per_meter;
    len_hit_d = alen_d > set_length;
    set_hit_d = ev_d >= set_count;
    des_hit_d = ev_d >= designated_count;
  end

  // Counter and threshold registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      len_q     <= CNT_RST;
      ev_q      <= CNT_RST;
      alen_q    <= CNT_RST;
      len_hit_q <= 1'b0;
      set_hit_q <= 1'b0;
      des_hit_q <= 1'b0;
    end else begin
      len_q     <= len_d;
      ev_q      <= ev_d;
      alen_q    <= alen_d;
      len_hit_q <= len_hit_d;
      set_hit_q <= set_hit_d;
      des_hit_q <= des_hit_d;
    end
  end

  // Output terminal mapping
  logic [NUM_DO-1:0] do_q, do_d;
  always_comb begin
    for (int j = 0; j < NUM_DO; j++) begin
      do_d[j] = ((do_func[6*j +: 6] == DO_SET_CNT) & set_hit_q)
              | ((do_func[6*j +: 6] == DO_DES_CNT) & des_hit_q)
              | ((do_func[6*j +: 6] == DO_LEN_REACH) & len_hit_q);
    end
  end

  // Output terminal registers
  always_ff @(posedge ref_clk) begin
    if (srst) do_q <= '0;
    else do_q <= do_d;
  end

  // Counter results
  assign actual_length = alen_q;
  assign event_count   = ev_q;
  assign dout          = do_q;

  // Counter checks
  a_count_stops: assert property (@(posedge ref_clk) disable iff (srst)
    (ev_q >= set_count && !cnt_rst) |=> ev_q == $past(ev_q)) else $error("counter moved past set");
  a_count_step: assert property (@(posedge ref_clk) disable iff (srst)
    (cnt_pulse && !cnt_rst && ev_q < set_count) |=> ev_q == $past(ev_q) + 32'h1)
    else $error("count pulse lost");
  a_set_output: assert property (@(posedge ref_clk) disable iff (srst)
    (set_hit_q && do_func[5:0] == DO_SET_CNT) |=> dout[0]) else $error("set count output missing");
  a_des_output: assert property (@(posedge ref_clk) disable iff (srst)
    (des_hit_q && do_func[11:6] == DO_DES_CNT) |=> dout[1]) else $error("designated output missing");

  // Direction checks
  a_inhibit_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (reverse_inhibit && rev_run && !fwd_run) |=> target_freq == '0 && !output_enable)
    else $error("reverse not inhibited");
  a_inhibit_neg: assert property (@(posedge ref_clk) disable iff (srst)
    (reverse_inhibit && fset[FW]) |=> target_freq == '0 && !output_enable)
    else $error("negative set not inhibited");
  a_dir_invert: assert property (@(posedge ref_clk) disable iff (srst)
    (!reverse_inhibit && fwd_run && !rev_run && !fset[FW]) |=> run_reverse == $past(direction_invert))
    else $error("direction invert not applied");

  // Length checks
  // Length function not on the fifth input
  sequence s_len_off;
    !len_assigned;
  endsequence
  // Pin to edge takes two cycles in the sync chain
  sequence s_no_len_edge;
    ##2 !len_pulse;
  endsequence
  a_len_reset: assert property (@(posedge ref_clk) disable iff (srst)
    len_rst |=> len_q == '0) else $error("length not cleared");
  a_len_step: assert property (@(posedge ref_clk) disable iff (srst)
    (len_pulse && !len_rst) |=> len_q == $past(len_q) + 32'h1) else $error("length pulse lost");
  a_len_pin: assert property (@(posedge ref_clk) disable iff (srst)
    s_len_off |-> s_no_len_edge) else $error("length pulse from a foreign terminal");

endmodule // freq_ref_core

// ==== bench/term_model.sv ====
// Terminal model that emits pulse trains on the fifth digital input
`timescale 1ns/1ps
module term_model (
  // Clock
  input  wire logic       ref_clk,
  // Train request
  input  wire logic       go,
  input  wire logic [7:0] n,
  // Terminal side
  output logic            pulse,
  output logic            busy
);
  logic [7:0] rem = 8'h00;
  logic [1:0] ph  = 2'h0;

  // Each pulse is two cycles high, two low, idle low
  initial busy = 1'b0;
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      rem  <= n;
      busy <= (n != 8'h00);
      ph   <= 2'h0;
    end else if (busy) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        rem <= rem - 8'h01;
        busy <= (rem != 8'h01);
      end
    end
  end
  assign pulse = busy && (ph < 2'h2);
endmodule // term_model

// ==== bench/tb.sv ====
// Self-checking bench for the frequency reference and pulse counter block
`timescale 1ns/1ps
module tb;
  import freq_ref_pkg::*;
  logic ref_clk, srst, direction_invert, reverse_inhibit, pid_auto_sel, fwd_run, rev_run;
  logic switch_pin, pid_switch_pin, go, pulse, busy, run_reverse, output_enable;
  logic [3:0]  main_source_select, aux_source_select, dout;
  logic [2:0]  source_relation_select;
  logic [1:0]  combine_op, command_source_select;
  logic [11:0] binding_select;
  logic [8:0]  curve_select;
  logic [319:0] curve_points;
  logic [47:0] ain_pct;
  logic [63:0] pulse_points;
  logic [15:0] max_frequency, dig_vol_freq, dig_ret_freq, comm_freq, target_freq;
  logic [15:0] pulse_rate_khz10, plc_pct, pid1_pct, pid2_pct;
  logic [15:0] ms_table [16];
  logic [9:0]  di_static, di;
  logic [59:0] di_func;
  logic [23:0] do_func;
  logic [31:0] pulses_per_meter, set_length, set_count, designated_count, actual_length, event_count;
  logic [7:0]  n_pulse;
  logic [15:0] exp_op [4];
  int          n_mismatch, total_checks;

  assign di = di_static | {5'h00, pulse, 4'h0};

  freq_ref_core i_dut (
    .ref_clk(ref_clk), .srst(srst), .main_source_select(main_source_select),
    .aux_source_select(aux_source_select), .source_relation_select(source_relation_select),
    .combine_op(combine_op), .command_source_select(command_source_select),
    .binding_select(binding_select), .max_frequency(max_frequency),
    .direction_invert(direction_invert), .reverse_inhibit(reverse_inhibit),
    .curve_select(curve_select), .curve_points(curve_points), .ain_pct(ain_pct),
    .pulse_points(pulse_points), .pulse_rate_khz10(pulse_rate_khz10),
    .dig_vol_freq(dig_vol_freq), .dig_ret_freq(dig_ret_freq), .plc_pct(plc_pct),
    .comm_freq(comm_freq), .pid1_pct(pid1_pct), .pid2_pct(pid2_pct),
    .pid_auto_sel(pid_auto_sel), .ms_table(ms_table), .di(di), .di_func(di_func),
    .do_func(do_func), .fwd_run(fwd_run), .rev_run(rev_run), .switch_pin(switch_pin),
    .pid_switch_pin(pid_switch_pin), .pulses_per_meter(pulses_per_meter),
    .set_length(set_length), .set_count(set_count), .designated_count(designated_count),
    .target_freq(target_freq), .run_reverse(run_reverse), .output_enable(output_enable),
    .actual_length(actual_length), .event_count(event_count), .dout(dout)
  );

  term_model i_term (.ref_clk(ref_clk), .go(go), .n(n_pulse), .pulse(pulse), .busy(busy));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] n);
    n_pulse = n;
    go = 1'b1;
    step(1);
    go = 1'b0;
    for (int w = 0; w < 2000 && busy; w++) step(1);
    if (busy) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
      conclude();
    end
  endtask

  task automatic do_reset();
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    di_func = '0;
    do_func = '0;
    step(1);
  endtask

  // Direct, combined and switched channels
  task automatic test_relation();
    main_source_select = SRC_DIG_VOL;
    aux_source_select = SRC_DIG_RET;
    source_relation_select = REL_A;
    step(3);
    chk(target_freq, 16'h03E8);
    source_relation_select = REL_B;
    step(3);
    chk(target_freq, 16'h012C);
    source_relation_select = REL_OP;
    for (int k = 0; k < 4; k++) begin
      combine_op = 2'(k);
      step(3);
      chk(target_freq, exp_op[k]);
    end
    source_relation_select = REL_SW_AB;
    switch_pin = 1'b1;
    step(3);
    chk(target_freq, 16'h012C);
    switch_pin = 1'b0;
    step(3);
    chk(target_freq, 16'h03E8);
    command_source_select = 2'h1;
    binding_select = 12'h020;
    step(3);
    chk(target_freq, 16'h012C);
    binding_select = 12'h000;
    $display("test relation done");
  endtask

  // Multi-speed with two assigned bits, analog full scale
  task automatic test_speed();
    main_source_select = SRC_MULTI;
    di_func[5:0] = FN_MS_BIT0;
    di_func[11:6] = FN_MS_BIT0 + 6'h01;
    di_static = 10'h006;
    step(5);
    chk(target_freq, 16'h0064);
    di_static = 10'h000;
    di_func = '0;
    main_source_select = SRC_AIN1;
    step(3);
    chk(target_freq, 16'h1388);
    $display("test speed done");
  endtask

  // Sign, inversion and reverse inhibit
  task automatic test_direction();
    main_source_select = SRC_COMM;
    comm_freq = 16'hFE0C;
    step(3);
    chk(target_freq, 16'h01F4);
    chk(run_reverse, 1'b1);
    chk(output_enable, 1'b1);
    reverse_inhibit = 1'b1;
    step(3);
    chk(target_freq, 16'h0000);
    chk(output_enable, 1'b0);
    comm_freq = 16'h01F4;
    fwd_run = 1'b0;
    rev_run = 1'b1;
    step(3);
    chk(target_freq, 16'h0000);
    reverse_inhibit = 1'b0;
    fwd_run = 1'b1;
    rev_run = 1'b0;
    direction_invert = 1'b1;
    step(3);
    chk(run_reverse, 1'b1);
    direction_invert = 1'b0;
    step(3);
    chk(run_reverse, 1'b0);
    $display("test direction done");
  endtask

  // Event counter with designated and set thresholds
  task automatic test_counter();
    do_reset();
    {fwd_run, rev_run} = 2'b00;
    di_func[29:24] = FN_COUNT_IN;
    do_func[5:0] = DO_SET_CNT;
    do_func[11:6] = DO_DES_CNT;
    set_count = 32'h0000_0005;
    designated_count = 32'h0000_0003;
    send(8'h03);
    step(4);
    chk(event_count, 32'h0000_0003);
    chk(dout[1:0], 2'b10);
    send(8'h04);
    step(4);
    chk(event_count, 32'h0000_0005);
    chk(dout[1:0], 2'b11);
    di_func[35:30] = FN_CNT_RST;
    di_static[5] = 1'b1;
    step(3);
    chk(event_count, 32'h0000_0000);
    di_static[5] = 1'b0;
    fwd_run = 1'b1;
    $display("test counter done");
  endtask

  // Length count, strict compare, reset, wrong terminal
  task automatic test_length();
    do_reset();
    di_func[29:24] = FN_LEN_IN;
    di_func[35:30] = FN_LEN_RST;
    do_func[17:12] = DO_LEN_REACH;
    send(8'h04);
    step(4);
    chk(actual_length, 32'h0000_0002);
    chk(dout[2], 1'b0);
    send(8'h02);
    step(4);
    chk(actual_length, 32'h0000_0003);
    chk(dout[2], 1'b1);
    di_static[5] = 1'b1;
    step(5);
    chk(actual_length, 32'h0000_0000);
    di_static[5] = 1'b0;
    di_func[5:0] = FN_LEN_IN;
    for (int k = 0; k < 6; k++) begin
      di_static[0] = ~di_static[0];
      step(2);
    end
    step(4);
    chk(actual_length, 32'h0000_0000);
    $display("test length done");
  endtask

  // Curve choice, pulse line and PID units
  task automatic test_source();
    main_source_select = SRC_AIN1;
    curve_points[127:64] = {16'h1388, 16'h2710, 16'h0000, 16'h0000};
    curve_select = 9'h001;
    step(3);
    chk(target_freq, 16'h09C4);
    curve_select = 9'h000;
    main_source_select = SRC_PULSE;
    pulse_points = {16'h2710, 16'h2710, 16'h0000, 16'h0000};
    pulse_rate_khz10 = 16'h1388;
    step(3);
    chk(target_freq, 16'h09C4);
    main_source_select = SRC_PID;
    pid1_pct = 16'h1388;
    pid2_pct = 16'h09C4;
    step(3);
    chk(target_freq, 16'h09C4);
    pid_switch_pin = 1'b1;
    step(3);
    chk(target_freq, 16'h04E2);
    pid_switch_pin = 1'b0;
    $display("test source done");
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    {direction_invert, reverse_inhibit, pid_auto_sel, rev_run, switch_pin, pid_switch_pin, go} = '0;
    fwd_run = 1'b1;
    {main_source_select, aux_source_select, source_relation_select, combine_op} = '0;
    {command_source_select, binding_select, curve_select, ain_pct, pulse_points} = '0;
    curve_points = '0;
    curve_points[63:0] = {16'h2710, 16'h2710, 16'h0000, 16'h0000};
    ain_pct[15:0] = PCT_FULL;
    {pulse_rate_khz10, plc_pct, pid1_pct, pid2_pct, comm_freq} = '0;
    max_frequency = 16'h1388;
    dig_vol_freq = 16'h03E8;
    dig_ret_freq = 16'h012C;
    for (int k = 0; k < 16; k++) ms_table[k] = 16'(k * 100);
    exp_op = '{16'h0514, 16'h02BC, 16'h03E8, 16'h012C};
    {di_static, di_func, do_func, n_pulse} = '0;
    {set_count, designated_count} = '0;
    pulses_per_meter = 32'h0000_0002;
    set_length = 32'h0000_0002;
    srst = 1'b1;
    step(20);
    srst = 1'b0;
    step(1);
    test_relation();
    test_speed();
    test_source();
    test_direction();
    test_counter();
    test_length();
    conclude();
  end

  // Watchdog
  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end
endmodule // tb
